// *** hw/plst_pkg.sv ***
// Purpose: shared constants and types for the link power state timers
// Assumes: one 250 MHz core clock, registers on a 32-bit AXI4-Lite slave
// Notes:   all offsets are byte addresses of aligned 32-bit words
package plst_pkg;

  // clock and timer tick
  localparam int CLK_PERIOD_NS = 4;            // core clock period
  localparam int TICK_NS       = 4;            // timer unit
  // least time, so round up, never under one cycle
  localparam int TICK_CYCLES_RAW = (TICK_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
  localparam int TICK_CYCLES   = (TICK_CYCLES_RAW < 1) ? 1 : TICK_CYCLES_RAW;

  // timer widths
  localparam int L0S_W     = 16;               // l0s idle timeout width
  localparam int L1E_W     = 20;               // aspm l1 entry width
  localparam int REENTRY_W = 32;               // l1 re-entry wait width

  // register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;  // control bits
  localparam logic [7:0] OFF_L0S     = 8'h04;  // l0s idle timeout
  localparam logic [7:0] OFF_L1E     = 8'h08;  // aspm l1 entry timeout
  localparam logic [7:0] OFF_REENTRY = 8'h0c;  // l1 re-entry wait
  localparam logic [7:0] OFF_STATUS  = 8'h10;  // read-only status

  // control field positions
  localparam int CTRL_CAPTURE_BIT  = 0;        // slot power capture enable
  localparam int CTRL_ENDPOINT_BIT = 1;        // core acts as an endpoint

  // status field positions
  localparam int ST_STATE_LSB  = 0;            // link state, 2 bits
  localparam int ST_ARMED_BIT  = 2;            // re-entry wait armed
  localparam int ST_VALUE_LSB  = 8;            // slot limit value, 8 bits
  localparam int ST_SCALE_LSB  = 16;           // slot limit scale, 2 bits

  // values after reset
  localparam logic [L0S_W-1:0]     L0S_RST      = 16'h0100;
  localparam logic [L1E_W-1:0]     L1E_RST      = 20'h00400;
  localparam logic [REENTRY_W-1:0] REENTRY_RST  = 32'h00001000;
  localparam logic                 CAPTURE_RST  = 1'h0;
  localparam logic                 ENDPOINT_RST = 1'h1;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // link power state
  typedef enum logic [1:0] {
    LNK_L0  = 2'b00,
    LNK_L0S = 2'b01,
    LNK_L1  = 2'b10
  } plst_link_e;

  // software configuration
  typedef struct packed {
    logic                 capture_en;          // slot_power_capture_enable
    logic                 endpoint;            // endpoint mode
    logic [L0S_W-1:0]     l0s_idle_timeout;
    logic [L1E_W-1:0]     aspm_l1_entry_timeout;
    logic [REENTRY_W-1:0] l1_reentry_wait;
  } plst_cfg_s;

  // decoded set slot power limit message
  typedef struct packed {
    logic       valid;                         // one-cycle strobe
    logic [7:0] value;                         // limit value
    logic [1:0] scale;                         // limit scale
  } plst_slot_msg_s;

  // captured device capabilities fields
  typedef struct packed {
    logic [7:0] value;
    logic [1:0] scale;
  } plst_slot_s;

endpackage

// *** hw/plst_idle_timer.sv ***
// Purpose: idle interval timer counting in tick units
// Assumes: tick is a one-cycle enable on the core clock
// Notes:   a zero limit never fires; fires once per idle stretch
module plst_idle_timer
  import plst_pkg::*;
#(
  parameter int W = 16                         // counter width
)
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         tick,              // timer unit enable
  input  wire logic         run,               // low restarts the count
  input  wire logic [W-1:0] limit,             // interval in ticks
  output logic              fire               // one-cycle pulse
);

  // refuse widths the counter cannot serve
  if (W < 1 || W > 32)
  begin : g_bad_w
    $error("plst_idle_timer: W must be 1 to 32");
  end

  logic [W-1:0] count;                         // elapsed ticks
  logic         done;                          // fired this idle stretch
  logic [W-1:0] next_count;
  logic         next_done;
  logic         next_fire;

  // count ticks while idle, restart on activity
  always_comb
  begin
    next_count = count;
    next_done  = done;
    next_fire  = 1'b0;
    if (!run)
    begin
      // activity or disabled: start over
      next_count = '0;
      next_done  = 1'b0;
    end
    else if (tick && !done && limit != '0)                        // RQ12
    begin
      next_count = W'(count + W'(1));
      if (next_count == limit)
      begin
        // reached the configured interval
        next_fire = 1'b1;
        next_done = 1'b1;
      end
    end
  end

  // register the timer state
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      count <= '0;
      done  <= 1'b0;
      fire  <= 1'b0;
    end
    else
    begin
      count <= next_count;
      done  <= next_done;
      fire  <= next_fire;
    end
  end

  // a zero limit never lets the timer fire
  a_fire_nonzero: assert property (@(posedge clk) disable iff (rst) // RQ12
    fire |-> $past(limit) != '0)
    else $error("timer fired with a zero limit");

  // firing means the count just reached the limit
  a_fire_at_limit: assert property (@(posedge clk) disable iff (rst) // RQ12
    fire |-> (count == $past(limit)) && $past(run))
    else $error("timer fired away from its limit");

endmodule

// *** hw/plst_top.sv ***
// Purpose: link power state timers with an AXI4-Lite register slave
// Assumes: link activity inputs come from logic on the same clock
// Notes:   link state outputs are commands to the link layer
//
// Overview of operation
// RQ1 - tx idle for timeout: idle sequence, enter L0s
// RQ2 - L0s timeout is 16 bits of 4 ns
// RQ3 - zero L0s timeout never enters L0s
// RQ4 - after partner wake in D3, wait re-entry delay
// RQ5 - D3, L0, no activity for delay: enter L1
// RQ6 - zero re-entry delay blocks return to L1
// RQ7 - first L1 entry immediate when all D3
// RQ8 - ASPM L1 timeout is 20 bits of 4 ns
// RQ9 - zero ASPM L1 timeout never enters L1
// RQ10 - capture on, endpoint: message loads slot fields
// RQ11 - capture off: slot fields stay unchanged
// RQ12 - timers tick 4 ns, restart on activity
//
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
module plst_top
  import plst_pkg::*;
#(
  parameter int ADDR_W = 8                     // axi address width
)
(
  input  wire logic              clk,
  input  wire logic              rst,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // link side
  input  wire logic              tx_active,    // transmit activity
  input  wire logic              rx_active,    // receive activity
  input  wire logic              link_wake,    // link returned to L0
  input  wire logic              all_d3,       // every function in D3
  input  wire plst_slot_msg_s    slot_msg,     // slot power message
  output plst_link_e             link_state,   // commanded power state
  output logic                   send_idle_seq, // pulse: send idle set
  output logic                   go_l0s,       // pulse: enter L0s
  output logic                   go_l1,        // pulse: enter L1
  output plst_slot_s             slot_limit    // capabilities fields
);

  // the word decode reads address bits 7:2, so eight bits at the least
  if (ADDR_W < 8 || ADDR_W > 32)
  begin : g_bad_addr
    $error("plst_top: ADDR_W must be 8 to 32");
  end

  // merge a write under its byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[i*8 +: 8] = data[i*8 +: 8];
    end
    return res;
  endfunction

  // tick divider: 4 ns units from the core clock
  logic [7:0] div_cnt;                         // cycles within a tick
  logic       tick;                            // one-cycle unit pulse
  logic [7:0] next_div_cnt;
  logic       next_tick;

  always_comb
  begin
    next_tick    = 1'b0;
    next_div_cnt = 8'(div_cnt + 8'h01);
    if (div_cnt == 8'(TICK_CYCLES - 1))
    begin
      // end of one unit; at 250 MHz this fires every cycle
      next_div_cnt = 8'h00;
      next_tick    = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      div_cnt <= 8'h00;
      tick    <= 1'b0;
    end
    else
    begin
      div_cnt <= next_div_cnt;
      tick    <= next_tick;
    end
  end

  // bus group: handshake state and configuration
  plst_cfg_s         cfg, next_cfg;            // software settings
  logic              aw_full, next_aw_full;    // write address held
  logic [ADDR_W-1:0] aw_addr, next_aw_addr;
  logic              w_full, next_w_full;      // write data held
  logic [31:0]       w_data, next_w_data;
  logic [3:0]        w_strb, next_w_strb;
  logic              next_awready, next_wready, next_bvalid;
  logic [1:0]        next_bresp, next_rresp;
  logic              next_arready, next_rvalid;
  logic [31:0]       next_rdata;
  logic [7:0]        wr_off, rd_off;           // word-aligned offsets
  logic [31:0]       status_word;              // live block state
  logic              armed;                    // re-entry wait pending

  assign wr_off = {aw_addr[7:2], 2'b00};
  assign rd_off = {s_axi_araddr[7:2], 2'b00};

  always_comb
  begin
    status_word = '0;
    status_word[ST_STATE_LSB +: 2] = link_state;
    status_word[ST_ARMED_BIT]      = armed;
    status_word[ST_VALUE_LSB +: 8] = slot_limit.value;
    status_word[ST_SCALE_LSB +: 2] = slot_limit.scale;
  end

  // address and data are taken in either order, answered once both
  always_comb
  begin
    logic [31:0] cur;
    cur          = '0;
    next_cfg     = cfg;
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full  = w_full;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_arready = s_axi_arready;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    if (aw_full && w_full && !s_axi_bvalid)
    begin
      // both halves present: perform the write
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OKAY;
      if ((aw_addr >> 8) != '0)
        next_bresp = RESP_SLVERR;              // above the map
      else
      begin
        case (wr_off)
          OFF_CTRL:
          begin
            cur = merge({30'h0, cfg.endpoint, cfg.capture_en},
                        w_data, w_strb);
            next_cfg.capture_en = cur[CTRL_CAPTURE_BIT];
            next_cfg.endpoint   = cur[CTRL_ENDPOINT_BIT];
          end
          OFF_L0S:
          begin
            cur = merge({16'h0, cfg.l0s_idle_timeout}, w_data, w_strb);
            next_cfg.l0s_idle_timeout = cur[L0S_W-1:0];           // RQ2
          end
          OFF_L1E:
          begin
            cur = merge({12'h0, cfg.aspm_l1_entry_timeout},
                        w_data, w_strb);
            next_cfg.aspm_l1_entry_timeout = cur[L1E_W-1:0];      // RQ8
          end
          OFF_REENTRY:
          begin
            cur = merge(cfg.l1_reentry_wait, w_data, w_strb);
            next_cfg.l1_reentry_wait = cur;                       // RQ4
          end
          OFF_STATUS: next_bresp = RESP_OKAY;  // read-only, write ignored
          default:    next_bresp = RESP_SLVERR;
        endcase
      end
    end
    // only one read in flight; arready drops until the data is taken
    if (s_axi_rvalid && s_axi_rready)
    begin
      next_rvalid  = 1'b0;
      next_arready = 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_arready = 1'b0;
      next_rvalid  = 1'b1;
      next_rresp   = RESP_OKAY;
      next_rdata   = '0;
      if ((s_axi_araddr >> 8) != '0)
        next_rresp = RESP_SLVERR;
      else
      begin
        case (rd_off)
          OFF_CTRL:    next_rdata = {30'h0, cfg.endpoint, cfg.capture_en};
          OFF_L0S:     next_rdata = {16'h0, cfg.l0s_idle_timeout};
          OFF_L1E:     next_rdata = {12'h0, cfg.aspm_l1_entry_timeout};
          OFF_REENTRY: next_rdata = cfg.l1_reentry_wait;
          OFF_STATUS:  next_rdata = status_word;
          default:     next_rresp = RESP_SLVERR;
        endcase
      end
    end
    next_awready = !next_aw_full;
    next_wready  = !next_w_full;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cfg           <= '{CAPTURE_RST, ENDPOINT_RST, L0S_RST, L1E_RST,
                         REENTRY_RST};
      aw_full       <= 1'b0;
      aw_addr       <= '0;
      w_full        <= 1'b0;
      w_data        <= '0;
      w_strb        <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      cfg           <= next_cfg;
      aw_full       <= next_aw_full;
      aw_addr       <= next_aw_addr;
      w_full        <= next_w_full;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

  // idle timers; each restarts on the activity that matters to it
  logic l0s_fire, l1e_fire, reentry_fire;
  logic any_active;
  assign any_active = tx_active || rx_active;

  plst_idle_timer #(.W(L0S_W)) u_l0s_timer (
    .clk   (clk),
    .rst   (rst),
    .tick  (tick),
    .run   (link_state == LNK_L0 && !tx_active),                  // RQ1
    .limit (cfg.l0s_idle_timeout),
    .fire  (l0s_fire)
  );

  plst_idle_timer #(.W(L1E_W)) u_l1e_timer (
    .clk   (clk),
    .rst   (rst),
    .tick  (tick),
    .run   (link_state != LNK_L1 && !any_active),                 // RQ8
    .limit (cfg.aspm_l1_entry_timeout),
    .fire  (l1e_fire)
  );

  plst_idle_timer #(.W(REENTRY_W)) u_reentry_timer (
    .clk   (clk),
    .rst   (rst),
    .tick  (tick),
    .run   (armed && all_d3 && link_state == LNK_L0 && !any_active), // RQ5
    .limit (cfg.l1_reentry_wait),
    .fire  (reentry_fire)
  );

  // power group: link state, entry pulses, d3 tracking, slot fields
  plst_link_e next_state;
  logic       d3_seen, next_d3_seen;           // first D3 entry done
  logic       next_armed, next_idle, next_l0s, next_l1;
  plst_slot_s next_slot;

  always_comb
  begin
    next_state   = link_state;
    next_d3_seen = d3_seen && all_d3;          // leaving D3 rearms it
    next_armed   = armed && all_d3;
    next_idle    = 1'b0;
    next_l0s     = 1'b0;
    next_l1      = 1'b0;
    next_slot    = slot_limit;
    case (link_state)
      LNK_L0, LNK_L0S:
      begin
        if (all_d3 && !d3_seen)
        begin
          // first D3 entry goes to L1 at once, delay not consulted
          next_state   = LNK_L1;                                  // RQ7
          next_d3_seen = 1'b1;
          next_l1      = 1'b1;
        end
        else if (reentry_fire || l1e_fire)
        begin
          // a zero limit never fires, so zero blocks this path
          next_state = LNK_L1;                            // RQ5 RQ6 RQ9
          next_l1    = 1'b1;
          next_armed = 1'b0;
        end
        else if (link_state == LNK_L0S)
        begin
          if (tx_active || link_wake)
            next_state = LNK_L0;
        end
        else if (l0s_fire && !tx_active)
        begin
          // zero timeout never fires, so L0s stays unreachable
          next_state = LNK_L0S;                           // RQ1 RQ3
          next_idle  = 1'b1;
          next_l0s   = 1'b1;
        end
      end
      LNK_L1:
      begin
        if (link_wake)
        begin
          // partner woke the link: start the re-entry wait if in D3
          next_state = LNK_L0;
          next_armed = all_d3;                                    // RQ4
        end
      end
      default: next_state = LNK_L0;
    endcase
    if (slot_msg.valid && cfg.capture_en && cfg.endpoint)
    begin
      next_slot.value = slot_msg.value;                           // RQ10
      next_slot.scale = slot_msg.scale;
    end
    // otherwise the captured fields hold their value             // RQ11
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      link_state    <= LNK_L0;
      d3_seen       <= 1'b0;
      armed         <= 1'b0;
      send_idle_seq <= 1'b0;
      go_l0s        <= 1'b0;
      go_l1         <= 1'b0;
      slot_limit    <= '0;
    end
    else
    begin
      link_state    <= next_state;
      d3_seen       <= next_d3_seen;
      armed         <= next_armed;
      send_idle_seq <= next_idle;
      go_l0s        <= next_l0s;
      go_l1         <= next_l1;
      slot_limit    <= next_slot;
    end
  end

  a_l0s_entry: assert property (@(posedge clk) disable iff (rst) // RQ1
    go_l0s |-> send_idle_seq && link_state == LNK_L0S && $past(!tx_active))
    else $error("L0s entered without idle sequence or while sending");

  a_l0s_zero_off: assert property (@(posedge clk) disable iff (rst) // RQ3
    go_l0s |-> $past(cfg.l0s_idle_timeout, 2) != '0)
    else $error("L0s entered with a zero timeout");

  a_first_d3_l1: assert property (@(posedge clk) disable iff (rst) // RQ7
    (all_d3 && !d3_seen && link_state != LNK_L1)
      |=> go_l1 && link_state == LNK_L1)
    else $error("first D3 entry did not move the link to L1");

  a_reentry_cause: assert property (@(posedge clk) disable iff (rst) // RQ5
    (go_l1 && !$past(l1e_fire) && $past(d3_seen))
      |-> $past(reentry_fire) && $past(all_d3))
    else $error("L1 re-entry without an expired wait in D3");

  a_reentry_zero: assert property (@(posedge clk) disable iff (rst) // RQ6
    reentry_fire |-> $past(cfg.l1_reentry_wait) != '0)
    else $error("re-entry wait expired with a zero setting");

  a_aspm_zero: assert property (@(posedge clk) disable iff (rst) // RQ9
    l1e_fire |-> $past(cfg.aspm_l1_entry_timeout) != '0)
    else $error("ASPM L1 timer expired with a zero setting");

  a_slot_capture: assert property (@(posedge clk) disable iff (rst) // RQ10
    (slot_msg.valid && cfg.capture_en && cfg.endpoint)
      |=> slot_limit == {$past(slot_msg.value), $past(slot_msg.scale)})
    else $error("slot power message not captured");

  a_slot_hold: assert property (@(posedge clk) disable iff (rst) // RQ11
    !(slot_msg.valid && cfg.capture_en && cfg.endpoint)
      |=> $stable(slot_limit))
    else $error("slot power fields changed without capture");

endmodule

// *** verification/plst_partner_model.sv ***
// Purpose: behavioural link partner for the power state timers bench
// Assumes: bench commands arrive on the core clock
// Notes:   message lines toggle while no message is sent
module plst_partner_model
  import plst_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       wake_req,  // bench asks for a wake to L0
  input  wire logic       rx_req,    // bench asks for rx traffic
  input  wire logic       msg_req,   // bench asks for a slot message
  input  wire logic [7:0] msg_val,   // limit value to send
  input  wire logic [1:0] msg_scl,   // limit scale to send
  output logic            rx_active,
  output logic            link_wake,
  output plst_slot_msg_s  slot_msg
);
  timeunit 1ns;
  timeprecision 1ps;

  // quiet link at time zero
  initial
  begin
    rx_active = 1'b0;
    link_wake = 1'b0;
    slot_msg  = '0;
  end

  // one registered stage, like a real transmitter adds
  always @(posedge clk)
  begin
    link_wake <= wake_req;
    rx_active <= rx_req;
    if (msg_req)
      slot_msg <= {1'b1, msg_val, msg_scl};
    else
      // released lines invert, so a stale value is never trusted
      slot_msg <= {1'b0, ~slot_msg.value, ~slot_msg.scale};
  end
endmodule

// *** verification/plst_top_tb.sv ***
// Purpose: self-checking bench for the link power state timers
// Assumes: small timeouts written over the register bus
// Notes:   timeout values are drawn from a fixed seed
module plst_top_tb
  import plst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic           clk, rst, tx, d3, wake, msg, awv, wv, arv, rxq;
  logic           awr, wr_r, bv, arr, rv, rxa, lw, sis, g0s, gl1;
  logic [7:0]     awa, ara, mval;
  logic [31:0]    wd, rd, v;
  logic [1:0]     br, rr, mscl, r;
  plst_link_e     ls;
  plst_slot_s     sl, exp_sl;
  plst_slot_msg_s smsg;
  int             n_errors, compares, seed, n, lim;
  int             cyc = 0;       // watchdog cycle count

  plst_top u_plst_top (.clk(clk), .rst(rst),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(1'b1), .tx_active(tx),
    .rx_active(rxa), .link_wake(lw), .all_d3(d3), .slot_msg(smsg),
    .link_state(ls), .send_idle_seq(sis), .go_l0s(g0s), .go_l1(gl1),
    .slot_limit(sl));

  plst_partner_model u_plst_partner_model (.clk(clk), .wake_req(wake),
    .rx_req(rxq), .msg_req(msg), .msg_val(mval), .msg_scl(mscl),
    .rx_active(rxa), .link_wake(lw), .slot_msg(smsg));

  // 250 MHz core clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want)
    begin
      n_errors++;
      $display("BAD t=%0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic final_report();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // write: each channel released at its own take, response last
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, t;
    @(posedge clk);
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    ta = 1'b0;
    tw = 1'b0;
    while (!(ta && tw))
    begin
      @(negedge clk);
      ta = ta | (awv & awr);
      tw = tw | (wv & wr_r);
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end
    do
    begin
      @(negedge clk);
      t = bv;
      r = br;
    end
    while (!t);
  endtask

  task automatic rdr(input logic [7:0] a);
    logic t;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    do
    begin
      @(negedge clk);
      t = arr;
      @(posedge clk);
    end
    while (!t);
    arv <= 1'b0;
    do
    begin
      @(negedge clk);
      t = rv;
      v = rd;
      r = rr;
    end
    while (!t);
  endtask

  // edges until a go pulse shows, capped at lim
  task automatic wp(input bit l1);
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (!(l1 ? gl1 : g0s) && n < lim);
  endtask

  task automatic wk();
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
  endtask

  function automatic int rnd(input int base, input int span);
    return base + ($unsigned($random(seed)) % span);
  endfunction

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      n_errors++;
      final_report();
    end
  end

  initial
  begin
    {rst, tx} = 2'b11;
    {d3, wake, msg, awv, wv, arv, rxq} = '0;
    {awa, ara, wd, mval, mscl} = '0;
    {n_errors, compares, n, lim, exp_sl} = '0;
    seed = 76;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rdr(OFF_CTRL);
    chk(v, {30'h0, ENDPOINT_RST, CAPTURE_RST});
    rdr(OFF_L0S);
    chk(v, 32'(L0S_RST));
    // bits above each timer field are dropped
    wr(OFF_L0S, 32'hffffffff);
    rdr(OFF_L0S);
    chk(v, 32'h0000ffff);
    wr(OFF_L1E, 32'hffffffff);
    rdr(OFF_L1E);
    chk(v, 32'h000fffff);
    wr(OFF_L1E, 0);
    chk(r, RESP_OKAY);
    wr(OFF_REENTRY, 0);
    // l0s entry, with one burst of tx that must restart the count
    repeat (3)
    begin
      lim = rnd(3, 8);
      wr(OFF_L0S, lim);
      @(posedge clk);
      tx <= 1'b0;
      repeat (lim - 1) @(posedge clk);
      tx <= 1'b1;
      @(posedge clk);
      tx <= 1'b0;
      v = lim + 1;
      lim = 100;
      wp(0);
      chk(n, v);
      chk(sis, 1'b1);
      chk(ls, LNK_L0S);
      @(posedge clk);
      tx <= 1'b1;
      repeat (2) @(posedge clk);
    end
    // zero timeouts never fire
    wr(OFF_L0S, 0);
    @(posedge clk);
    tx <= 1'b0;
    lim = 60;
    wp(0);
    chk(n, 60);
    wp(1);
    chk(n, 60);
    @(posedge clk);
    tx <= 1'b1;
    v = rnd(3, 8);
    wr(OFF_L1E, v);
    @(posedge clk);
    tx <= 1'b0;
    // one rx burst just short of expiry must restart the count
    repeat (v - 3) @(posedge clk);
    rxq <= 1'b1;
    @(posedge clk);
    rxq <= 1'b0;
    wp(1);
    chk(n, v + 2);
    chk(ls, LNK_L1);
    wr(OFF_L1E, 0);
    wk();
    lim = rnd(5, 16);
    wr(OFF_REENTRY, lim);
    @(posedge clk);
    d3 <= 1'b1;
    v = lim;
    wp(1);
    chk(n, 1);
    wk();
    lim = 200;
    wp(1);
    chk(n >= v && n <= v + 6, 1'b1);
    wr(OFF_REENTRY, 0);
    wk();
    lim = 60;
    wp(1);
    chk(n, 60);
    chk(ls, LNK_L0);
    // control values 3, 0, 1, 2: only the first captures
    for (int i = 0; i < 4; i++)
    begin
      wr(OFF_CTRL, (i + 3) % 4);
      v = $random(seed);
      @(posedge clk);
      mval <= v[7:0];
      mscl <= v[9:8];
      msg  <= 1'b1;
      @(posedge clk);
      msg <= 1'b0;
      repeat (3) @(posedge clk);
      if (i == 0) exp_sl = {v[7:0], v[9:8]};
      if (i == 0) chk(sl, exp_sl);
      else chk(sl, exp_sl);
    end
    // status is read-only: a write is answered and ignored
    wr(OFF_STATUS, 32'hffffffff);
    chk(r, RESP_OKAY);
    rdr(OFF_STATUS);
    chk(v & 32'h0003ff07, {14'h0, exp_sl.scale, exp_sl.value, 8'h04});
    wr(8'h14, 32'hffffffff);
    chk(r, RESP_SLVERR);
    rdr(8'h14);
    chk(v, 32'h0);
    chk(r, RESP_SLVERR);
    final_report();
  end
endmodule
